/* File: core/sar_seq_defines.vh */
`ifndef SAR_SEQ_DEFINES_VH
`define SAR_SEQ_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_RESULT 12'h008

// ****************************************
// control byte fields
// ****************************************
`define BIT_PWR_HI 7
`define BIT_PWR_LO 6
`define BIT_ACQ_MODE 5
`define BIT_IN_CFG 4
`define BIT_POLARITY 3
`define ADDR_MSB 2
`define ADDR_LSB 0
`define PWR_FULL_DOWN 2'h0
`define PWR_STANDBY 2'h1
`define PWR_INT_CLK 2'h2
`define PWR_EXT_CLK 2'h3

// ****************************************
// status fields
// ****************************************
`define ST_TRACK 0
`define ST_ACQ_EXT 1
`define ST_BUSY 2
`define ST_DONE 3
`define ST_EXT_CLK 4
`define ST_VALID 5

// ****************************************
// reset values
// ****************************************
`define RST_CTRL 8'hC0
`define RST_EXT_CLK 1'h1

// ****************************************
// timing
// ****************************************
`define PCLK_PERIOD_NS 4
`define INT_CONV_TIME_NS 3600
`define CONV_CYCLES 13
`define INT_CLK_PERIOD_NS (`INT_CONV_TIME_NS / `CONV_CYCLES)
`define INT_CLK_DIV (`INT_CLK_PERIOD_NS / `PCLK_PERIOD_NS)
`define ACQ_EDGES 4
`define SAR_BITS 12

`endif

/* File: core/sar_adc_acquisition_sequencer.v */
// Implementation choices: the APB interface to the registers and the placing of the registers.
`include "sar_seq_defines.vh"
`default_nettype none

// Operation
// - write puts track/hold into tracking
// - external mode: next write switches to hold
// - internal mode: hold at fourth clock fall
// - conversion takes thirteen conversion-clock cycles
// - write during conversion aborts, restarts acquisition
// - mode bit zero: self-timed acquisition
// - conversion starts when self-timed acquisition ends
// - mode bit one: acquire until next write
// - mode-zero second write ends acquisition, converts
// - single-ended: positive to channel, negative to common
// - differential: nodes to channel pair members
// - conversion moves hold cap, then 12-bit approximation
// - end of conversion or a new acquisition reconnects hold cap to positive
// - done low when ready; released by result read or control write
// - bit 5 selects acquisition mode
// - bit 4 selects single-ended or differential
// - bits 7:6 select power and clock mode
module sar_adc_acquisition_sequencer (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // converter side
    input wire chip_select_n,
    input wire ext_conv_clk,
    input wire comparator_out,
    // analog switch controls
    output reg track_en,
    output reg hold_cap_to_neg,
    output reg [2:0] pos_node_sel,
    output reg [2:0] neg_node_sel,
    output reg neg_to_common,
    output reg [11:0] dac_code,
    output reg polarity_select,
    output reg [1:0] power_state,
    output reg conv_done_n
);

    // ****************************************
    // state machine
    // ****************************************
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_ACQ_INT = 4'h2;
    localparam [3:0] S_ACQ_EXT = 4'h4;
    localparam [3:0] S_CONV = 4'h8;
    // counts are cut to their counter widths on purpose
    localparam [31:0] DIV_LAST_W = `INT_CLK_DIV - 1;
    localparam [31:0] ACQ_LAST_W = `ACQ_EDGES - 1;
    localparam [31:0] CONV_LAST_W = `CONV_CYCLES - 1;
    localparam [6:0] DIV_LAST = DIV_LAST_W[6:0];
    localparam [3:0] ACQ_LAST = ACQ_LAST_W[3:0];
    localparam [3:0] CONV_LAST = CONV_LAST_W[3:0];

    function [2:0] pair_partner;
        input [2:0] addr;
        begin
            pair_partner = {addr[2:1], ~addr[0]};
        end
    endfunction

    reg [3:0] state_ff;
    reg [7:0] ctrl_ff;
    reg ext_clk_mode_ff;
    reg ext_clk_prev_ff;
    reg [6:0] div_ff;
    reg [3:0] edge_cnt_ff;
    reg [11:0] trial_bit_ff;
    reg [11:0] result_ff;
    reg result_valid_ff;

    wire setup_rd;
    wire access_done;
    wire hit_ctrl;
    wire hit_status;
    wire hit_result;
    wire ctrl_write;
    wire result_read;
    wire int_tick;
    wire conv_edge;
    wire [7:0] wbyte;
    wire conv_start;

    // ****************************************
    // apb slave, one wait state
    // ****************************************
    assign hit_ctrl = (paddr == `OFS_CTRL);
    assign hit_status = (paddr == `OFS_STATUS);
    assign hit_result = (paddr == `OFS_RESULT);
    // first access edge raises pready and captures the read data
    assign setup_rd = psel & penable & ~pready;
    assign access_done = psel & penable & pready;
    // a deselected chip drops the control write on the floor
    assign ctrl_write = access_done & pwrite & hit_ctrl
        & ~chip_select_n;
    assign result_read = access_done & ~pwrite & hit_result;
    assign wbyte = pwdata[7:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            pready <= 1'b1;
            pslverr <= ~(hit_ctrl | hit_status | hit_result);
            if (hit_ctrl) begin
                prdata <= {24'h000000, ctrl_ff};
            end else if (hit_status) begin
                prdata <= {26'h0000000, result_valid_ff,
                    ext_clk_mode_ff, ~conv_done_n, state_ff[3],
                    state_ff[2], track_en};
            end else if (hit_result) begin
                prdata <= {20'h00000, result_ff};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ****************************************
    // conversion clock edges
    // ****************************************
    // internal oscillator is a divider; its tick stands for a falling edge
    // the pin is sampled by pclk, so it must run well below half of pclk
    assign int_tick = (div_ff == DIV_LAST);
    assign conv_edge = ~chip_select_n & (ext_clk_mode_ff ?
        (ext_clk_prev_ff & ~ext_conv_clk) : int_tick);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 7'h00;
            ext_clk_prev_ff <= 1'b0;
        end else begin
            ext_clk_prev_ff <= ext_conv_clk;
            if (int_tick | ctrl_write) begin
                div_ff <= 7'h00;
            end else begin
                div_ff <= div_ff + 7'h01;
            end
        end
    end

    // ****************************************
    // control byte and clock mode
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `RST_CTRL;
            ext_clk_mode_ff <= `RST_EXT_CLK;
            power_state <= `PWR_EXT_CLK;
            polarity_select <= 1'b0;
        end else if (ctrl_write) begin
            ctrl_ff <= wbyte;
            power_state <= wbyte[`BIT_PWR_HI:`BIT_PWR_LO];
            polarity_select <= wbyte[`BIT_POLARITY];
            // power-down codes keep the last clock mode
            if (wbyte[`BIT_PWR_HI]) begin
                ext_clk_mode_ff <= wbyte[`BIT_PWR_LO];
            end
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    // second write of external acquisition only ends it; its mux bits
    // are not reloaded, so a host changing them corrupts only itself
    // a write landing on the fourth edge wins and restarts acquisition
    assign conv_start = (ctrl_write & state_ff[2]
        & ~wbyte[`BIT_ACQ_MODE])
        | (state_ff[1] & conv_edge & ~ctrl_write
        & (edge_cnt_ff == ACQ_LAST));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= S_IDLE;
            track_en <= 1'b0;
            hold_cap_to_neg <= 1'b0;
            pos_node_sel <= 3'h0;
            neg_node_sel <= 3'h0;
            neg_to_common <= 1'b1;
            edge_cnt_ff <= 4'h0;
            trial_bit_ff <= 12'h000;
            dac_code <= 12'h000;
        end else if (conv_start) begin
            state_ff <= S_CONV;
            track_en <= 1'b0;
            hold_cap_to_neg <= 1'b1;
            edge_cnt_ff <= 4'h0;
            trial_bit_ff <= 12'h800;
            dac_code <= 12'h800;
        end else if (ctrl_write) begin
            // any other write aborts and opens a new acquisition
            track_en <= 1'b1;
            hold_cap_to_neg <= 1'b0;
            edge_cnt_ff <= 4'h0;
            dac_code <= 12'h000;
            pos_node_sel <= wbyte[`ADDR_MSB:`ADDR_LSB];
            if (wbyte[`BIT_IN_CFG]) begin
                neg_to_common <= 1'b1;
                neg_node_sel <= 3'h0;
            end else begin
                neg_to_common <= 1'b0;
                neg_node_sel <=
                    pair_partner(wbyte[`ADDR_MSB:`ADDR_LSB]);
            end
            if (wbyte[`BIT_ACQ_MODE]) begin
                state_ff <= S_ACQ_EXT;
            end else begin
                state_ff <= S_ACQ_INT;
            end
        end else begin
            case (state_ff)
                S_ACQ_INT: begin
                    if (conv_edge) begin
                        edge_cnt_ff <= edge_cnt_ff + 4'h1;
                    end
                end
                S_CONV: begin
                    if (conv_edge) begin
                        edge_cnt_ff <= edge_cnt_ff + 4'h1;
                        if (edge_cnt_ff == CONV_LAST) begin
                            state_ff <= S_IDLE;
                            hold_cap_to_neg <= 1'b0;
                        end else if (trial_bit_ff != 12'h000) begin
                            // comparator high keeps the trial bit
                            if (comparator_out) begin
                                dac_code <= dac_code
                                    | (trial_bit_ff >> 1);
                            end else begin
                                dac_code <= (dac_code & ~trial_bit_ff)
                                    | (trial_bit_ff >> 1);
                            end
                            trial_bit_ff <= trial_bit_ff >> 1;
                        end
                    end
                end
                S_ACQ_EXT: begin
                    state_ff <= S_ACQ_EXT;
                end
                S_IDLE: begin
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // result and done flag
    // ****************************************
    wire conv_finish;
    assign conv_finish = state_ff[3] & conv_edge
        & (edge_cnt_ff == CONV_LAST) & ~ctrl_write;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff <= 12'h000;
            result_valid_ff <= 1'b0;
            conv_done_n <= 1'b1;
        end else begin
            if (conv_finish) begin
                result_ff <= dac_code;
                result_valid_ff <= 1'b1;
            end else if (ctrl_write) begin
                // result word survives a write; only its valid flag drops
                result_valid_ff <= 1'b0;
            end
            // a finish in the same cycle as a read wins over the release
            if (conv_finish) begin
                conv_done_n <= 1'b0;
            end else if (result_read | ctrl_write) begin
                conv_done_n <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: verification/comparator_model.sv */
`default_nettype none
// ****
// comparator seen by the sequencer
// ****
module comparator_model (
    // held level and trial code
    input wire logic [11:0] vin,
    input wire logic [11:0] dac_code,
    // decision
    output logic comparator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // at-or-above keeps the trial bit, so the final code equals vin
    assign comparator_out = vin >= dac_code;
endmodule
`default_nettype wire

/* File: verification/sar_seq_checker.sv */
`include "sar_seq_defines.vh"
`default_nettype none
// ****
// port timing of the sequencer
// ****
module sar_seq_checker (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // converter
    input wire logic chip_select_n,
    input wire logic ext_conv_clk,
    input wire logic track_en,
    input wire logic hold_cap_to_neg,
    input wire logic [2:0] pos_node_sel,
    input wire logic [2:0] neg_node_sel,
    input wire logic neg_to_common,
    input wire logic [11:0] dac_code,
    input wire logic [1:0] power_state,
    input wire logic conv_done_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prv_ff, ext_ff, ck_ff;
    logic [3:0] acq_ff, cnv_ff;
    logic [7:0] wd_ff;
    // edges only count in external clock mode with the chip selected
    // power-down codes keep the last clock mode, so track it here
    wire fall = prv_ff & ~ext_conv_clk & ~chip_select_n & ck_ff;
    wire wc = psel & penable & pready & pwrite & ~chip_select_n
        & (paddr == `OFS_CTRL);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prv_ff <= 1'b0;
            ext_ff <= 1'b0;
            ck_ff <= `RST_EXT_CLK;
            acq_ff <= 4'h0;
            cnv_ff <= 4'h0;
            wd_ff <= 8'h00;
        end else begin
            prv_ff <= ext_conv_clk;
            wd_ff <= pwdata[7:0];
            if (wc) begin
                ext_ff <= pwdata[`BIT_ACQ_MODE];
                if (pwdata[`BIT_PWR_HI]) ck_ff <= pwdata[`BIT_PWR_LO];
            end
            acq_ff <= wc ? 4'h0 : acq_ff + {3'h0, fall & track_en};
            cnv_ff <= hold_cap_to_neg ? cnv_ff + {3'h0, fall} : 4'h0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_track_on_write: assert property (
        wc && (pwdata[5] || !ext_ff) |=> track_en) else $error("no track");
    chk_ext_end_hold: assert property (
        wc && !pwdata[5] && ext_ff |=> !track_en && hold_cap_to_neg)
        else $error("no hold on second write");
    chk_hold_fourth: assert property (
        fall && track_en && !ext_ff && !wc && acq_ff == 4'h3
        |=> !track_en && hold_cap_to_neg && dac_code == 12'h800)
        else $error("hold not at fourth fall");
    chk_conv_thirteen: assert property (
        fall && hold_cap_to_neg && !wc && cnv_ff == 4'hC
        |=> !conv_done_n && !hold_cap_to_neg) else $error("not 13 cycles");
    chk_abort_restart: assert property (
        wc && hold_cap_to_neg |=> track_en && !hold_cap_to_neg)
        else $error("no abort");
    chk_done_release: assert property (
        wc && !(fall && hold_cap_to_neg) |=> conv_done_n)
        else $error("done kept");
    chk_mux_route: assert property (
        wc && !ext_ff |=> pos_node_sel == wd_ff[2:0]
        && neg_to_common == wd_ff[4] && neg_node_sel ==
        (wd_ff[4] ? 3'h0 : wd_ff[2:0] ^ 3'h1)) else $error("bad route");
    chk_power_bits: assert property (
        wc |=> power_state == wd_ff[7:6]) else $error("bad power");
    chk_cs_ignore: assert property (
        psel && penable && pready && pwrite && chip_select_n
        |=> $stable(track_en) && $stable(power_state))
        else $error("deselected write taken");
    chk_result_held: assert property (
        !conv_done_n && !wc |=> $stable(dac_code)) else $error("result lost");
endmodule
bind sar_adc_acquisition_sequencer sar_seq_checker i_sar_seq_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .chip_select_n, .ext_conv_clk, .track_en, .hold_cap_to_neg,
    .pos_node_sel, .neg_node_sel, .neg_to_common, .dac_code, .power_state,
    .conv_done_n);
`default_nettype wire

/* File: verification/tb_sar_adc_acquisition_sequencer.sv */
`include "sar_seq_defines.vh"
`default_nettype none
module tb_sar_adc_acquisition_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic chip_select_n = 0, ext_conv_clk = 0, comparator_out, track_en;
    logic hold_cap_to_neg, neg_to_common, polarity_select, conv_done_n;
    logic pready, pslverr;
    logic [11:0] paddr = 0, vin = 0, dac_code;
    logic [31:0] pwdata = 0, prdata, rd, seed = 15;
    logic [2:0] pos_node_sel, neg_node_sel, ediv = 0;
    logic [1:0] power_state;
    logic [7:0] c;
    int err_total = 0, total_checks = 0, cyc = 0, i;
    sar_adc_acquisition_sequencer i_sar_adc_acquisition_sequencer (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .chip_select_n, .ext_conv_clk, .comparator_out,
        .track_en, .hold_cap_to_neg, .pos_node_sel, .neg_node_sel,
        .neg_to_common, .dac_code, .polarity_select, .power_state,
        .conv_done_n);
    comparator_model i_comparator_model (.vin, .dac_code, .comparator_out);
    initial forever #2 pclk = ~pclk;
    // conversion clock at one sixteenth of pclk, bounded run time
    always @(posedge pclk) begin
        ediv <= ediv + 3'h1;
        if (ediv == 3'h7) ext_conv_clk <= ~ext_conv_clk;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [3:0] exp_neg(input logic [7:0] b);
        return b[4] ? 4'h8 : {1'b0, b[2:0] ^ 3'h1};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] b);
        apb(1'b1, `OFS_CTRL, {24'h0, b});
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (conv_done_n !== 1'b0 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        cmp(n < 4000, 1);
    endtask
    task automatic finish_conv;
        wait_done;
        apb(1'b0, `OFS_RESULT, 0);
        cmp(rd[11:0], vin);
        cmp({er, conv_done_n}, 2'b01);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        cmp({track_en, hold_cap_to_neg, neg_to_common, power_state,
            conv_done_n}, 6'h0F);
        // every power code, each opening an open-ended acquisition
        for (i = 0; i < 4; i++) begin
            wr({i[1:0], 6'h20});
            cmp({track_en, power_state}, {1'b1, i[1:0]});
            apb(1'b0, `OFS_STATUS, 0);
            cmp(rd[5:1], {1'b0, i != 2, 3'b001});
        end
        vin <= 12'h5A3;
        repeat (40) @(posedge pclk);
        cmp(track_en, 1);
        wr(8'hC0);
        cmp({track_en, hold_cap_to_neg}, 2'b01);
        finish_conv;
        // self-timed acquisitions, extreme levels first
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            vin <= (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : seed[11:0];
            c = {3'b110, i[0], seed[19:16]};
            wr(c);
            cmp({track_en, pos_node_sel, exp_neg(c), polarity_select},
                {1'b1, c[2:0], neg_to_common, neg_node_sel, c[3]});
            finish_conv;
        end
        wr(8'hDB);
        repeat (150) @(posedge pclk);
        cmp(hold_cap_to_neg, 1);
        wr(8'hD9);
        cmp({track_en, hold_cap_to_neg, conv_done_n}, 3'b101);
        finish_conv;
        @(posedge pclk);
        chip_select_n <= 1'b1;
        wr(8'h60);
        cmp({track_en, power_state}, 3'b011);
        @(posedge pclk);
        chip_select_n <= 1'b0;
        apb(1'b0, 12'h00C, 0);
        cmp(er, 1);
        wr(8'h8A);
        finish_conv;
        // a write with the result still unread releases done
        wr(8'hDB);
        wait_done;
        wr(8'hD9);
        cmp(conv_done_n, 1);
        apb(1'b0, `OFS_STATUS, 0);
        cmp(rd[5:3], 3'b010);
        finish_conv;
        tally_and_finish;
    end
endmodule
`default_nettype wire
